// ===== lpmc_defs.vh
// register offsets, field positions, mode codes and timing figures of the low-power controller
`ifndef LPMC_DEFS_VH
`define LPMC_DEFS_VH

// register offsets (4-bit data, 10-bit address)
`define LPMC_ADDR_IRQ_FLAGS   10'h001
`define LPMC_ADDR_IRQ_CTRL    10'h002
`define LPMC_ADDR_MODE_STAT   10'h003
`define LPMC_ADDR_TIMER_MODE  10'h008
`define LPMC_ADDR_AUX_CTRL    10'h00c
`define LPMC_ADDR_LOW_POWER   10'h020

// field positions
`define LPMC_BIT_EXT0_FLAG    0
`define LPMC_BIT_TA_FLAG      2
`define LPMC_BIT_IRQ_ENABLE   0
`define LPMC_BIT_TA_MASK      1
`define LPMC_BIT_EXT0_MASK    2
`define LPMC_BIT_TIMEBASE     3
`define LPMC_BIT_LOW_SPEED    0
`define LPMC_BIT_DIRECT       3

// reset values
`define LPMC_RST_IRQ_CTRL     4'h6
`define LPMC_RST_AUX_CTRL     2'h0

// operating modes
`define LPMC_MODE_ACTIVE      3'h0
`define LPMC_MODE_STANDBY     3'h1
`define LPMC_MODE_STOP        3'h2
`define LPMC_MODE_WATCH       3'h3
`define LPMC_MODE_SUBACTIVE   3'h4
`define LPMC_MODE_SETTLE      3'h5

// frame period selections (low prescaler bits that wrap per frame)
`define LPMC_FRAME_SEL_SHORT  2'h0
`define LPMC_FRAME_SEL_MID    2'h1
`define LPMC_FRAME_BITS_SHORT 3
`define LPMC_FRAME_BITS_MID   4
`define LPMC_FRAME_BITS_LONG  5

// oscillator settling time and clock period
`define LPMC_SETTLE_NS        1000
`define LPMC_CLK_PERIOD_NS    10

`endif

// ===== lpmc_low_power_ctrl.v
// low-power mode controller: mode sequencing, interrupt frame, wake-up and settling logic
`timescale 1ns/10ps
`include "lpmc_defs.vh"

// Overview of operation
// - standby instruction in active mode stops cpu clocks, keeps oscillators and timers running.
// - standby holds ram, registers and pin states unchanged.
// - standby ends on reset or interrupt request; interrupt resumes active mode.
// - after wake, interrupt is serviced only when irq_enable_flag is one.
// - stop instruction with clock_timebase_select_bit zero halts main oscillator and everything.
// - ram kept after stop; cpu working registers may be undefined.
// - watch entered by stop with timebase bit one, or stop/standby in subactive.
// - watch ends on reset or timer A/ext_irq0_n request; low_speed picks target.
// - watch to active waits settle time after the request is raised.
// - subactive clocks the cpu from the sub oscillator, active from main.
// - direct_transfer_flag settable only in subactive, cleared and read zero in active.
// - direct transfer moves subactive to active after a fixed settling time.
// - prescaler W alone makes the frame, period chosen by aux register; timer A counts full prescaler W wraps.
// - timer A and ext_irq0_n requests raised only at the strobe in low modes, except timer A in watch heading to active.
// - timer A overflow raised at the strobe in subactive and in watch with low_speed set, at once in watch otherwise.
// - in low modes, ext_irq0_n edge seen only from the samples taken at the strobe, raised at that strobe.
// - stop/standby coinciding with strobe in subactive discards pending requests.
// - ext_irq0_n sampled once per frame in low modes, every clock otherwise; edge is a high then low sample.
// - reset returns the controller to active from any mode.
// - low_speed_select_flag makes watch wake-ups target subactive instead of active.
module lpmc_low_power_ctrl
#(
  parameter SETTLE_CYCLES = (`LPMC_SETTLE_NS + `LPMC_CLK_PERIOD_NS - 1) / `LPMC_CLK_PERIOD_NS,
  parameter CNT_W         = 16
)
(
  // clock and reset
  input  wire       CLK_IN,
  input  wire       SYS_RST_IN,
  // register port
  input  wire [9:0] ADDR_IN,
  input  wire [3:0] WDATA_IN,
  input  wire       WR_IN,
  input  wire       RD_IN,
  output reg  [3:0] RDATA_OUT,
  // cpu instruction strobes
  input  wire       STOP_INSTR_IN,
  input  wire       SBY_INSTR_IN,
  // time base and external interrupt
  input  wire       SUB_TICK_IN,
  input  wire       EXT_IRQ0_N_IN,
  // mode and clock controls
  output reg  [2:0] MODE_OUT,
  output reg        CPU_CLK_RUN_OUT,
  output reg        CPU_CLK_SUB_OUT,
  output reg        MAIN_OSC_EN_OUT,
  output reg        PERIPH_RUN_OUT,
  output reg        PIN_HOLD_OUT,
  output reg        PIN_HIZ_OUT,
  output reg        IRQ_REQ_OUT,
  output reg        FRAME_STROBE_OUT
);

  // reset image of the interrupt control register, bit-selected per field below
  localparam [3:0] RST_CTRL = `LPMC_RST_IRQ_CTRL;

  // mode and control state
  reg  [2:0]       mode;
  reg  [2:0]       settle_target;
  reg  [CNT_W-1:0] settle_cnt;
  reg              irq_enable_flag;
  reg              ta_mask;
  reg              ext0_mask;
  reg              clock_timebase_select_bit;
  reg              low_speed_select_flag;
  reg              direct_transfer_flag;
  reg  [1:0]       aux_frame_sel;
  reg              timer_a_irq_flag;
  reg              ext_irq0_flag;
  // time base
  reg  [4:0]       prescaler_w;
  reg  [7:0]       timer_a;
  reg              ext0_last;
  reg              ta_pending;
  reg              ext0_pending;

  wire low_mode   = (mode == `LPMC_MODE_WATCH) || (mode == `LPMC_MODE_SUBACTIVE);
  wire halted     = (mode == `LPMC_MODE_STOP);
  wire sleep_req  = STOP_INSTR_IN || SBY_INSTR_IN;
  wire pending    = (timer_a_irq_flag && !ta_mask) || (ext_irq0_flag && !ext0_mask);
  wire sub_tick   = SUB_TICK_IN && !halted;
  wire wr_flags   = WR_IN && (ADDR_IN == `LPMC_ADDR_IRQ_FLAGS);

  // frame strobe: low bits of prescaler W wrap once per selected frame
  reg frame_wrap;
  always @*
  begin
    case (aux_frame_sel)
      `LPMC_FRAME_SEL_SHORT: frame_wrap = &prescaler_w[`LPMC_FRAME_BITS_SHORT-1:0];
      `LPMC_FRAME_SEL_MID:   frame_wrap = &prescaler_w[`LPMC_FRAME_BITS_MID-1:0];
      default:               frame_wrap = &prescaler_w[`LPMC_FRAME_BITS_LONG-1:0];
    endcase
  end

  wire strobe     = sub_tick && frame_wrap;
  wire ta_tick    = sub_tick && (&prescaler_w);
  wire ta_ovf     = ta_tick && (&timer_a);
  // a discarded frame is a sleep instruction landing on the strobe in subactive
  wire discard    = strobe && sleep_req && (mode == `LPMC_MODE_SUBACTIVE);
  // outside the low modes, edges are taken every clock; stop mode takes none
  wire ext0_fall_fast = !low_mode && !halted && ext0_last && !EXT_IRQ0_N_IN;
  wire ext0_fall_frame = strobe && ext0_last && !EXT_IRQ0_N_IN;
  // watch heading to active takes timer A at once, not at the strobe
  wire watch_fast = (mode == `LPMC_MODE_WATCH) && !low_speed_select_flag;

  // set events for the two interrupt flags
  wire ta_set   = !discard &&
                  ((!low_mode && ta_ovf) ||
                   (watch_fast && ta_ovf) ||
                   (low_mode && strobe && (ta_pending || ta_ovf)));
  wire ext0_set = !discard &&
                  (ext0_fall_fast ||
                   (low_mode && strobe && (ext0_pending || ext0_fall_frame)));

  // prescaler W and timer A; both freeze in stop mode
  always @(posedge CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      prescaler_w <= 5'h00;
      timer_a     <= 8'h00;
    end
    else
    begin
      if (sub_tick)
        prescaler_w <= prescaler_w + 5'h01;
      if (ta_tick)
        timer_a <= timer_a + 8'h01; // wraps to zero on overflow
    end
  end

  // ext_irq0_n sampling: every clock when fast, once per frame in low modes
  always @(posedge CLK_IN)
  begin
    if (SYS_RST_IN)
      ext0_last <= EXT_IRQ0_N_IN; // follows the pin so a line held low shows no false edge
    else if (!low_mode || strobe)
      ext0_last <= EXT_IRQ0_N_IN;
  end

  // timer A overflows seen mid-frame wait here for the next strobe; ext0_pending is never set
  always @(posedge CLK_IN)
  begin
    if (SYS_RST_IN || !low_mode)
    begin
      ta_pending   <= 1'b0;
      ext0_pending <= 1'b0;
    end
    else if (strobe)
    begin
      ta_pending   <= 1'b0;
      ext0_pending <= 1'b0;
    end
    else
    begin
      if (ta_ovf && !watch_fast)
        ta_pending <= 1'b1;
    end
  end

  // interrupt flags: software writes zero to clear, a set in the same cycle wins
  always @(posedge CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      timer_a_irq_flag <= 1'b0;
      ext_irq0_flag    <= 1'b0;
    end
    else
    begin
      if (ta_set)
        timer_a_irq_flag <= 1'b1;
      else if (wr_flags && !WDATA_IN[`LPMC_BIT_TA_FLAG])
        timer_a_irq_flag <= 1'b0;
      if (ext0_set)
        ext_irq0_flag <= 1'b1;
      else if (wr_flags && !WDATA_IN[`LPMC_BIT_EXT0_FLAG])
        ext_irq0_flag <= 1'b0;
    end
  end

  // control registers written by software
  always @(posedge CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      irq_enable_flag           <= RST_CTRL[`LPMC_BIT_IRQ_ENABLE];
      ta_mask                   <= RST_CTRL[`LPMC_BIT_TA_MASK];
      ext0_mask                 <= RST_CTRL[`LPMC_BIT_EXT0_MASK];
      clock_timebase_select_bit <= 1'b0;
      low_speed_select_flag     <= 1'b0;
      direct_transfer_flag      <= 1'b0;
      aux_frame_sel             <= `LPMC_RST_AUX_CTRL;
    end
    else
    begin
      if (WR_IN && ADDR_IN == `LPMC_ADDR_IRQ_CTRL)
      begin
        irq_enable_flag <= WDATA_IN[`LPMC_BIT_IRQ_ENABLE];
        ta_mask         <= WDATA_IN[`LPMC_BIT_TA_MASK];
        ext0_mask       <= WDATA_IN[`LPMC_BIT_EXT0_MASK];
      end
      if (WR_IN && ADDR_IN == `LPMC_ADDR_TIMER_MODE)
        clock_timebase_select_bit <= WDATA_IN[`LPMC_BIT_TIMEBASE];
      if (WR_IN && ADDR_IN == `LPMC_ADDR_AUX_CTRL)
        aux_frame_sel <= WDATA_IN[1:0];
      if (WR_IN && ADDR_IN == `LPMC_ADDR_LOW_POWER)
        low_speed_select_flag <= WDATA_IN[`LPMC_BIT_LOW_SPEED];
      // direct transfer bit: set only in subactive, forced clear in active
      if (mode == `LPMC_MODE_ACTIVE)
        direct_transfer_flag <= 1'b0;
      else if (WR_IN && ADDR_IN == `LPMC_ADDR_LOW_POWER &&
               mode == `LPMC_MODE_SUBACTIVE)
        direct_transfer_flag <= WDATA_IN[`LPMC_BIT_DIRECT];
    end
  end

  // mode sequencer
  reg [2:0] next_mode;
  reg [2:0] next_target;
  reg       next_load;
  always @*
  begin
    next_mode   = mode;
    next_target = settle_target;
    next_load   = 1'b0;
    case (mode)
      `LPMC_MODE_ACTIVE:
      begin
        // a sleep request with an unmasked flag and irq disabled is a no-op
        if (sleep_req && !(pending && !irq_enable_flag))
        begin
          if (SBY_INSTR_IN)
            next_mode = `LPMC_MODE_STANDBY;
          else if (clock_timebase_select_bit)
            next_mode = `LPMC_MODE_WATCH;
          else
            next_mode = `LPMC_MODE_STOP;
        end
      end
      `LPMC_MODE_STANDBY:
      begin
        if (pending)
          next_mode = `LPMC_MODE_ACTIVE;
      end
      `LPMC_MODE_STOP:
        next_mode = `LPMC_MODE_STOP;
      `LPMC_MODE_WATCH:
      begin
        if (pending)
        begin
          if (low_speed_select_flag)
            next_mode = `LPMC_MODE_SUBACTIVE;
          else
          begin
            next_mode   = `LPMC_MODE_SETTLE;
            next_target = `LPMC_MODE_ACTIVE;
            next_load   = 1'b1;
          end
        end
      end
      `LPMC_MODE_SUBACTIVE:
      begin
        if (sleep_req && !(pending && !irq_enable_flag))
        begin
          if (direct_transfer_flag && !low_speed_select_flag)
          begin
            next_mode   = `LPMC_MODE_SETTLE;
            next_target = `LPMC_MODE_ACTIVE;
            next_load   = 1'b1;
          end
          else
            next_mode = `LPMC_MODE_WATCH;
        end
      end
      `LPMC_MODE_SETTLE:
      begin
        if (settle_cnt == {CNT_W{1'b0}})
          next_mode = settle_target;
      end
      default:
        next_mode = `LPMC_MODE_ACTIVE;
    endcase
  end

  // mode register and fixed-length settling counter
  always @(posedge CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      mode          <= `LPMC_MODE_ACTIVE;
      settle_target <= `LPMC_MODE_ACTIVE;
      settle_cnt    <= {CNT_W{1'b0}};
    end
    else
    begin
      mode          <= next_mode;
      settle_target <= next_target;
      if (next_load)
        settle_cnt <= SETTLE_CYCLES[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
      else if (settle_cnt != {CNT_W{1'b0}})
        settle_cnt <= settle_cnt - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // clock and pin controls follow the mode one clock later, all registered
  always @(posedge CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      MODE_OUT         <= `LPMC_MODE_ACTIVE;
      CPU_CLK_RUN_OUT  <= 1'b1;
      CPU_CLK_SUB_OUT  <= 1'b0;
      MAIN_OSC_EN_OUT  <= 1'b1;
      PERIPH_RUN_OUT   <= 1'b1;
      PIN_HOLD_OUT     <= 1'b0;
      PIN_HIZ_OUT      <= 1'b0;
      IRQ_REQ_OUT      <= 1'b0;
      FRAME_STROBE_OUT <= 1'b0;
    end
    else
    begin
      MODE_OUT <= mode;
      // cpu runs only in active and subactive; standby stops its clocks
      CPU_CLK_RUN_OUT <= (mode == `LPMC_MODE_ACTIVE) ||
                         (mode == `LPMC_MODE_SUBACTIVE);
      CPU_CLK_SUB_OUT <= (mode == `LPMC_MODE_SUBACTIVE);
      // main oscillator off in stop, watch and subactive
      MAIN_OSC_EN_OUT <= (mode == `LPMC_MODE_ACTIVE) ||
                         (mode == `LPMC_MODE_STANDBY) ||
                         (mode == `LPMC_MODE_SETTLE);
      PERIPH_RUN_OUT  <= (mode == `LPMC_MODE_ACTIVE) ||
                         (mode == `LPMC_MODE_STANDBY) ||
                         (mode == `LPMC_MODE_SUBACTIVE);
      // pins hold in standby, watch and settle, float in stop; ram is never touched here
      PIN_HOLD_OUT    <= (mode == `LPMC_MODE_STANDBY) ||
                         (mode == `LPMC_MODE_WATCH) ||
                         (mode == `LPMC_MODE_SETTLE);
      PIN_HIZ_OUT     <= halted;
      // a pending request reaches the cpu only while it runs and irqs are on
      IRQ_REQ_OUT     <= pending && irq_enable_flag &&
                         ((mode == `LPMC_MODE_ACTIVE) ||
                          (mode == `LPMC_MODE_SUBACTIVE));
      FRAME_STROBE_OUT <= strobe;
    end
  end

  // register read port, data one clock after the strobe; unmapped reads zero
  always @(posedge CLK_IN)
  begin
    if (SYS_RST_IN)
      RDATA_OUT <= 4'h0;
    else if (RD_IN)
    begin
      case (ADDR_IN)
        `LPMC_ADDR_IRQ_FLAGS:  RDATA_OUT <= {1'b0, timer_a_irq_flag, 1'b0, ext_irq0_flag};
        `LPMC_ADDR_IRQ_CTRL:   RDATA_OUT <= {1'b0, ext0_mask, ta_mask, irq_enable_flag};
        `LPMC_ADDR_MODE_STAT:  RDATA_OUT <= {1'b0, mode};
        `LPMC_ADDR_TIMER_MODE: RDATA_OUT <= {clock_timebase_select_bit, 3'h0};
        `LPMC_ADDR_AUX_CTRL:   RDATA_OUT <= {2'h0, aux_frame_sel};
        // direct transfer reads zero whenever the mode is active
        `LPMC_ADDR_LOW_POWER:  RDATA_OUT <= {direct_transfer_flag &&
                                             (mode != `LPMC_MODE_ACTIVE),
                                             2'h0, low_speed_select_flag};
        default:               RDATA_OUT <= 4'h0;
      endcase
    end
  end

endmodule

// ===== lpmc_low_power_ctrl_tb.sv
// self-checking testbench for the low-power mode controller
`timescale 1ns/10ps
`include "lpmc_defs.vh"
module lpmc_low_power_ctrl_tb;
  localparam SETTLE = 4;
  localparam TDIV   = 4;
  reg        clk;
  reg        rst;
  reg  [9:0] addr;
  reg  [3:0] wdata;
  reg        wr;
  reg        rd;
  reg        stop_i;
  reg        sby_i;
  reg        fall_req;
  wire [3:0] rdata;
  wire [2:0] mode;
  wire       tick;
  wire       ext_n;
  wire       cpu_run;
  wire       cpu_sub;
  wire       osc_en;
  wire       periph;
  wire       pin_hold;
  wire       pin_hiz;
  wire       irq_req;
  wire       strobe;
  integer    num_errors;
  integer    cmp_count;
  integer    waited;

  lpmc_low_power_ctrl #(.SETTLE_CYCLES(SETTLE)) lpmc_low_power_ctrl_inst (.CLK_IN(clk),
    .SYS_RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
    .RDATA_OUT(rdata), .STOP_INSTR_IN(stop_i), .SBY_INSTR_IN(sby_i), .SUB_TICK_IN(tick),
    .EXT_IRQ0_N_IN(ext_n), .MODE_OUT(mode), .CPU_CLK_RUN_OUT(cpu_run), .CPU_CLK_SUB_OUT(cpu_sub),
    .MAIN_OSC_EN_OUT(osc_en), .PERIPH_RUN_OUT(periph), .PIN_HOLD_OUT(pin_hold),
    .PIN_HIZ_OUT(pin_hiz), .IRQ_REQ_OUT(irq_req), .FRAME_STROBE_OUT(strobe));
  lpmc_partner #(.TICK_DIV(TDIV), .HOLD(200)) lpmc_partner_inst (.clk_in(clk),
    .fall_req_in(fall_req), .sub_tick_out(tick), .ext_irq0_n_out(ext_n));

  always #5 clk = ~clk;

  task give_verdict;
  begin
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask

  task chk(input [7:0] got, input [7:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask

  task wr_reg(input [9:0] a, input [3:0] d);
  begin
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  end
  endtask

  task rd_reg(input [9:0] a, input [3:0] exp);
  begin
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk({4'h0, rdata}, {4'h0, exp});
  end
  endtask

  // one-cycle instruction strobe, stop or standby
  task instr(input is_stop);
  begin
    @(posedge clk);
    stop_i <= is_stop;
    sby_i  <= !is_stop;
    @(posedge clk);
    stop_i <= 1'b0;
    sby_i  <= 1'b0;
  end
  endtask

  // bounded wait for a mode; a timeout closes the run
  task wait_mode(input [2:0] m);
  begin
    waited = 0;
    while (mode !== m && waited < 600)
    begin
      @(posedge clk);
      #1;
      waited = waited + 1;
    end
    chk({5'h0, mode}, {5'h0, m});
    if (mode !== m)
      give_verdict;
  end
  endtask

  // waits for the line to idle high, then asks the source for a falling edge
  task ext_fall;
    integer i;
  begin
    for (i = 0; i < 900 && ext_n !== 1'b1; i = i + 1)
      @(posedge clk);
    fall_req <= 1'b1;
    for (i = 0; i < 900 && ext_n !== 1'b0; i = i + 1)
      @(posedge clk);
    fall_req <= 1'b0;
    chk({7'h0, ext_n}, 8'h0);
    if (ext_n !== 1'b0)
      give_verdict;
  end
  endtask

  // measures the strobe gap for every frame selection
  task frame_sel;
    integer s;
    integer n;
    integer i;
  begin
    for (s = 0; s < 4; s = s + 1)
    begin
      wr_reg(`LPMC_ADDR_AUX_CTRL, s[3:0]);
      for (n = 0; n < 3; n = n + 1)
      begin
        @(posedge clk);
        #1;
        for (i = 0; i < 300 && strobe !== 1'b1; i = i + 1)
          @(posedge clk);
      end
      chk(i[7:0], 8'((s == 0 ? 8 : s == 1 ? 16 : 32) * TDIV - 1));
    end
    wr_reg(`LPMC_ADDR_AUX_CTRL, 4'h0);
  end
  endtask

  task standby_wake;
  begin
    wr_reg(`LPMC_ADDR_IRQ_CTRL, 4'h2);
    instr(1'b0);
    wait_mode(`LPMC_MODE_STANDBY);
    chk({5'h0, cpu_run, pin_hold, periph}, 8'h03);
    ext_fall;
    wait_mode(`LPMC_MODE_ACTIVE);
    rd_reg(`LPMC_ADDR_IRQ_FLAGS, 4'h1);
    chk({7'h0, irq_req}, 8'h0);
    instr(1'b0);
    repeat (4) @(posedge clk);
    #1;
    chk({5'h0, mode}, {5'h0, `LPMC_MODE_ACTIVE});
    wr_reg(`LPMC_ADDR_IRQ_CTRL, 4'h3);
    repeat (2) @(posedge clk);
    #1;
    chk({7'h0, irq_req}, 8'h1);
    wr_reg(`LPMC_ADDR_IRQ_FLAGS, 4'h0);
  end
  endtask

  task stop_reset;
  begin
    instr(1'b1);
    wait_mode(`LPMC_MODE_STOP);
    chk({5'h0, pin_hiz, osc_en, periph}, 8'h04);
    ext_fall;
    repeat (40) @(posedge clk);
    #1;
    chk({5'h0, mode}, {5'h0, `LPMC_MODE_STOP});
    rst <= 1'b1;
    repeat (SETTLE + 2) @(posedge clk);
    rst <= 1'b0;
    wait_mode(`LPMC_MODE_ACTIVE);
    rd_reg(`LPMC_ADDR_IRQ_CTRL, `LPMC_RST_IRQ_CTRL);
  end
  endtask

  task watch_wake;
  begin
    wr_reg(`LPMC_ADDR_IRQ_CTRL, 4'h2);
    wr_reg(`LPMC_ADDR_TIMER_MODE, 4'h8);
    instr(1'b1);
    wait_mode(`LPMC_MODE_WATCH);
    ext_fall;
    wait_mode(`LPMC_MODE_ACTIVE);
    chk({7'h0, waited > SETTLE && waited <= 2 * 8 * TDIV + SETTLE + 4}, 8'h1);
    wr_reg(`LPMC_ADDR_IRQ_FLAGS, 4'h0);
  end
  endtask

  task sub_direct;
  begin
    wr_reg(`LPMC_ADDR_LOW_POWER, 4'h8);
    rd_reg(`LPMC_ADDR_LOW_POWER, 4'h0);
    wr_reg(`LPMC_ADDR_LOW_POWER, 4'h1);
    instr(1'b1);
    wait_mode(`LPMC_MODE_WATCH);
    ext_fall;
    wait_mode(`LPMC_MODE_SUBACTIVE);
    chk({4'h0, cpu_run, cpu_sub, osc_en, periph}, 8'h0d);
    wr_reg(`LPMC_ADDR_IRQ_FLAGS, 4'h0);
    instr(1'b0);
    wait_mode(`LPMC_MODE_WATCH);
    ext_fall;
    wait_mode(`LPMC_MODE_SUBACTIVE);
    wr_reg(`LPMC_ADDR_IRQ_FLAGS, 4'h0);
    wr_reg(`LPMC_ADDR_LOW_POWER, 4'h8);
    rd_reg(`LPMC_ADDR_LOW_POWER, 4'h8);
    instr(1'b0);
    wait_mode(`LPMC_MODE_SETTLE);
    wait_mode(`LPMC_MODE_ACTIVE);
    rd_reg(`LPMC_ADDR_LOW_POWER, 4'h0);
  end
  endtask

  initial
  begin
    clk        = 1'b0;
    rst        = 1'b1;
    addr       = 10'h0;
    wdata      = 4'h0;
    wr         = 1'b0;
    rd         = 1'b0;
    stop_i     = 1'b0;
    sby_i      = 1'b0;
    fall_req   = 1'b0;
    num_errors = 0;
    cmp_count  = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd_reg(`LPMC_ADDR_IRQ_CTRL, `LPMC_RST_IRQ_CTRL);
    rd_reg(`LPMC_ADDR_MODE_STAT, 4'h0);
    rd_reg(10'h3ff, 4'h0);
    frame_sel;
    standby_wake;
    stop_reset;
    watch_wake;
    sub_direct;
    give_verdict;
  end
endmodule

// ===== lpmc_monitor.sv
// assertion checker watching the ports of the low-power mode controller
`timescale 1ns/10ps
`include "lpmc_defs.vh"
module lpmc_monitor
#(
  parameter SETTLE_CYCLES = 100
)
(
  input wire       CLK_IN,
  input wire       SYS_RST_IN,
  input wire       STOP_INSTR_IN,
  input wire       SBY_INSTR_IN,
  input wire [2:0] MODE_OUT,
  input wire       CPU_CLK_RUN_OUT,
  input wire       CPU_CLK_SUB_OUT,
  input wire       MAIN_OSC_EN_OUT,
  input wire       PERIPH_RUN_OUT,
  input wire       PIN_HOLD_OUT,
  input wire       PIN_HIZ_OUT,
  input wire       IRQ_REQ_OUT,
  input wire       FRAME_STROBE_OUT
);
  reg [15:0] settle_cnt;

  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  // counts settling cycles so a wrong settle length shows at the exit
  always @(posedge CLK_IN)
  begin
    if (SYS_RST_IN || MODE_OUT != `LPMC_MODE_SETTLE)
      settle_cnt <= 16'h0;
    else
      settle_cnt <= settle_cnt + 16'h1;
  end

  standby_entry_a: assert property (MODE_OUT == `LPMC_MODE_STANDBY && $past(MODE_OUT) != `LPMC_MODE_STANDBY |-> $past(SBY_INSTR_IN, 2)) else $error("standby entered without standby instruction");
  standby_clocks_a: assert property (MODE_OUT == `LPMC_MODE_STANDBY |-> !CPU_CLK_RUN_OUT && PERIPH_RUN_OUT && MAIN_OSC_EN_OUT && PIN_HOLD_OUT) else $error("standby clock or pin state wrong");
  stop_entry_a: assert property (MODE_OUT == `LPMC_MODE_STOP && $past(MODE_OUT) != `LPMC_MODE_STOP |-> $past(STOP_INSTR_IN, 2)) else $error("stop entered without stop instruction");
  stop_state_a: assert property (MODE_OUT == `LPMC_MODE_STOP |-> PIN_HIZ_OUT && !MAIN_OSC_EN_OUT && !CPU_CLK_RUN_OUT ##1 MODE_OUT == `LPMC_MODE_STOP) else $error("stop state left or not halted");
  watch_clocks_a: assert property (MODE_OUT == `LPMC_MODE_WATCH |-> PIN_HOLD_OUT && !PERIPH_RUN_OUT && !MAIN_OSC_EN_OUT && !CPU_CLK_RUN_OUT) else $error("watch clock state wrong");
  clock_source_a: assert property (CPU_CLK_RUN_OUT |-> CPU_CLK_SUB_OUT == (MODE_OUT == `LPMC_MODE_SUBACTIVE) && MAIN_OSC_EN_OUT == (MODE_OUT == `LPMC_MODE_ACTIVE)) else $error("cpu clock source wrong");
  settle_exit_a: assert property ($past(MODE_OUT) == `LPMC_MODE_SETTLE && MODE_OUT != `LPMC_MODE_SETTLE |-> MODE_OUT == `LPMC_MODE_ACTIVE && settle_cnt == SETTLE_CYCLES) else $error("settling length or target wrong");
  strobe_pulse_a: assert property (FRAME_STROBE_OUT |=> !FRAME_STROBE_OUT [*7]) else $error("frame strobe too close");
  irq_mode_a: assert property (IRQ_REQ_OUT |-> MODE_OUT == `LPMC_MODE_ACTIVE || MODE_OUT == `LPMC_MODE_SUBACTIVE) else $error("interrupt raised in sleeping mode");
endmodule

bind lpmc_low_power_ctrl lpmc_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES)) lpmc_monitor_inst
(
  .CLK_IN           (CLK_IN),
  .SYS_RST_IN       (SYS_RST_IN),
  .STOP_INSTR_IN    (STOP_INSTR_IN),
  .SBY_INSTR_IN     (SBY_INSTR_IN),
  .MODE_OUT         (MODE_OUT),
  .CPU_CLK_RUN_OUT  (CPU_CLK_RUN_OUT),
  .CPU_CLK_SUB_OUT  (CPU_CLK_SUB_OUT),
  .MAIN_OSC_EN_OUT  (MAIN_OSC_EN_OUT),
  .PERIPH_RUN_OUT   (PERIPH_RUN_OUT),
  .PIN_HOLD_OUT     (PIN_HOLD_OUT),
  .PIN_HIZ_OUT      (PIN_HIZ_OUT),
  .IRQ_REQ_OUT      (IRQ_REQ_OUT),
  .FRAME_STROBE_OUT (FRAME_STROBE_OUT)
);

// ===== lpmc_partner.sv
// far-side model: free-running sub-oscillator tick and external interrupt source
`timescale 1ns/10ps
module lpmc_partner
#(
  parameter TICK_DIV = 4,
  parameter HOLD     = 200
)
(
  input  wire clk_in,
  input  wire fall_req_in,
  output reg  sub_tick_out,
  output reg  ext_irq0_n_out
);
  reg [31:0] div_cnt;
  reg [31:0] hold_cnt;

  initial
  begin
    div_cnt        = 32'h0;
    hold_cnt       = 32'h0;
    sub_tick_out   = 1'b0;
    ext_irq0_n_out = 1'b1;
  end

  // sub oscillator runs free, so its tick never stops between frames
  always @(posedge clk_in)
  begin
    div_cnt      <= (div_cnt == TICK_DIV - 1) ? 32'h0 : div_cnt + 32'h1;
    sub_tick_out <= (div_cnt == TICK_DIV - 1);
  end

  // each level is held longer than the longest frame, else the edge is lost
  always @(posedge clk_in)
  begin
    if (hold_cnt != 32'h0)
      hold_cnt <= hold_cnt - 32'h1;
    else if (!ext_irq0_n_out || fall_req_in)
    begin
      ext_irq0_n_out <= !ext_irq0_n_out;
      hold_cnt       <= HOLD;
    end
  end
endmodule
